// *** dv/wake_input_cyclic_sense_cfg_test.sv ***
// Holds the self-checking bench of the wake input and cyclic timer block.
// Assumes the switch model on the pins and a shortened millisecond count.
`include "wake_cfg_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module wake_input_cyclic_sense_cfg_test;
  // Keeps the 0.1 ms on-time shorter than the 10 ms period.
  localparam int MS = 2000;
  logic CLOCK = 1'b0;
  logic RST_N = 1'b0;
  logic [6:0] REG_ADDR = 7'h00;
  logic REG_WRITE = 1'b0;
  logic [7:0] REG_WDATA = 8'h00;
  logic RESTART = 1'b0;
  logic HS_CLEARED = 1'b0;
  logic [2:0] HS_CONFIG = 3'h0;
  logic TIMER_TWO_ON_END = 1'b0;
  logic TIMER_A_WAKE_ENABLE = 1'b0;
  logic [2:0] closed = 3'h0;
  logic [2:0] WAKE_PIN, PULL_UP_ON, PULL_DOWN_ON, WAKE_LEVEL, WAKE_EVENT;
  logic [7:0] REG_RDATA;
  logic HIGH_SIDE_OUTPUT, TIMER_WAKE;
  int errors = 0;
  int check_count = 0;
  int cycles = 0;
  int n;
  // Pulses seen on the pin one wake event and on the timer wake output.
  int event_count = 0;
  int timer_wake_count = 0;
  wake_input_cyclic_sense_cfg #(.CYC_PER_MS(MS)) u_wake_input_cyclic_sense_cfg (.CLOCK(CLOCK), .RST_N(RST_N),
    .REG_ADDR(REG_ADDR), .REG_WRITE(REG_WRITE), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .RESTART(RESTART), .HS_CLEARED(HS_CLEARED), .HS_CONFIG(HS_CONFIG), .TIMER_TWO_ON_END(TIMER_TWO_ON_END),
    .TIMER_A_WAKE_ENABLE(TIMER_A_WAKE_ENABLE), .WAKE_PIN(WAKE_PIN), .PULL_UP_ON(PULL_UP_ON),
    .PULL_DOWN_ON(PULL_DOWN_ON), .WAKE_LEVEL(WAKE_LEVEL), .WAKE_EVENT(WAKE_EVENT),
    .HIGH_SIDE_OUTPUT(HIGH_SIDE_OUTPUT), .TIMER_WAKE(TIMER_WAKE));
  wake_switch_model u_wake_switch_model (.clock(CLOCK), .closed(closed), .pull_up_on(PULL_UP_ON),
    .pull_down_on(PULL_DOWN_ON), .wake_pin(WAKE_PIN));
  // The clock flips every half period of 25 ns.
  always #25 CLOCK = ~CLOCK;
  // Cuts a hang short well above the longest expected run.
  always @(posedge CLOCK)
  begin
    cycles <= cycles + 1;
    if (WAKE_EVENT[0] === 1'b1)
    begin
      event_count <= event_count + 1;
    end
    if (TIMER_WAKE === 1'b1)
    begin
      timer_wake_count <= timer_wake_count + 1;
    end
    if (cycles == 90000)
    begin
      errors++;
      give_verdict();
    end
  end
  // Compares one value and reports a mismatch at once.
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    check_count++;
    if (seen !== want)
    begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check
  // Writes one register with a single-cycle strobe.
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge CLOCK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WRITE <= 1'b1;
    @(posedge CLOCK);
    REG_WRITE <= 1'b0;
  endtask : wr
  // Presents an address and returns the data two cycles later.
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge CLOCK);
    REG_ADDR <= a;
    repeat (2) @(posedge CLOCK);
    d = REG_RDATA;
  endtask : rd
  // Waits, bounded, until the switch drive reaches the given level.
  task automatic wait_hs(input logic v, output int k);
    k = 0;
    while (HIGH_SIDE_OUTPUT !== v && k < 30000)
    begin
      @(posedge CLOCK);
      k++;
    end
  endtask : wait_hs
  // Checks reset values, reserved bits and an unmapped address.
  task automatic reg_scenario;
    logic [7:0] d;
    rd(`ADDR_WAKE_PULL, d); check(d, 8'h00);
    rd(`ADDR_TIMER_ONE, d); check(d, 8'h00);
    wr(`ADDR_WAKE_PULL, 8'hFF); rd(`ADDR_WAKE_PULL, d); check(d, 8'h3F);
    wr(`ADDR_WAKE_FILTER, 8'hC0); rd(`ADDR_WAKE_FILTER, d); check(d, 8'h00);
    wr(`ADDR_TIMER_ONE, 8'h88); rd(`ADDR_TIMER_ONE, d); check(d, 8'h00);
    rd(7'h0A, d); check(d, 8'h00);
  endtask : reg_scenario
  // Sets every pull code; auto mode must turn exactly one pull on.
  task automatic pull_scenario;
    wr(`ADDR_WAKE_PULL, 8'h24);
    repeat (3) @(posedge CLOCK);
    check(PULL_UP_ON, 3'h4);
    check(PULL_DOWN_ON, 3'h2);
    wr(`ADDR_WAKE_PULL, 8'h3F);
    repeat (3) @(posedge CLOCK);
    check(PULL_UP_ON ^ PULL_DOWN_ON, 3'h7);
  endtask : pull_scenario
  // Pin one on the short filter and pin two on the long one.
  task automatic static_scenario;
    wr(`ADDR_WAKE_PULL, 8'h15);
    wr(`ADDR_WAKE_FILTER, 8'h04);
    repeat (400) @(posedge CLOCK);
    closed <= 3'h3;
    repeat (340) @(posedge CLOCK);
    check(WAKE_LEVEL[1:0], 2'h1);
    repeat (960) @(posedge CLOCK);
    check(WAKE_LEVEL[1:0], 2'h3);
    closed <= 3'h0;
    repeat (1400) @(posedge CLOCK);
    check(WAKE_LEVEL, 3'h0);
    check(event_count, 2);
  endtask : static_scenario
  // Cyclic sensing on both timers and the timer one waveform.
  task automatic timer_scenario;
    HS_CONFIG <= `HS_CODE_TIMER_ONE;
    TIMER_A_WAKE_ENABLE <= 1'b1;
    wr(`ADDR_WAKE_FILTER, 8'h32);
    closed <= 3'h5;
    repeat (400) @(posedge CLOCK);
    check(WAKE_LEVEL, 3'h0);
    TIMER_TWO_ON_END <= 1'b1;
    @(posedge CLOCK);
    TIMER_TWO_ON_END <= 1'b0;
    repeat (5) @(posedge CLOCK);
    check(WAKE_LEVEL, 3'h4);
    wr(`ADDR_TIMER_ONE, 8'h10);
    wait_hs(1'b1, n); check(n < 5, 1'b1);
    check(WAKE_LEVEL[0], 1'b0);
    wait_hs(1'b0, n); check(n, MS / `TENTHS_PER_MS);
    repeat (5) @(posedge CLOCK);
    check(WAKE_LEVEL[0], 1'b1);
    check(event_count, 3);
    check(timer_wake_count, 1);
    // The on-time, the five idle cycles and this wait make up one period.
    wait_hs(1'b1, n); check(n + 5 + MS / `TENTHS_PER_MS, 10 * MS);
    wr(`ADDR_TIMER_ONE, 8'h60);
    repeat (5) @(posedge CLOCK);
    check(HIGH_SIDE_OUTPUT, 1'b1);
    wr(`ADDR_TIMER_ONE, 8'h00);
    repeat (5) @(posedge CLOCK);
    check(HIGH_SIDE_OUTPUT, 1'b0);
  endtask : timer_scenario
  // Clearing the switches under cyclic sense and a restart.
  task automatic restart_scenario;
    logic [7:0] d;
    wr(`ADDR_TIMER_ONE, 8'h21);
    @(posedge CLOCK);
    HS_CLEARED <= 1'b1;
    @(posedge CLOCK);
    HS_CLEARED <= 1'b0;
    rd(`ADDR_TIMER_ONE, d); check(d, 8'h00);
    wr(`ADDR_WAKE_PULL, 8'h2D);
    wr(`ADDR_TIMER_ONE, 8'h35);
    @(posedge CLOCK);
    RESTART <= 1'b1;
    @(posedge CLOCK);
    RESTART <= 1'b0;
    rd(`ADDR_WAKE_PULL, d); check(d, 8'h2D);
    rd(`ADDR_WAKE_FILTER, d); check(d, 8'h32);
    rd(`ADDR_TIMER_ONE, d); check(d, 8'h00);
  endtask : restart_scenario
  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict
  // Main sequence: reset for two cycles, then every scenario in turn.
  initial
  begin
    repeat (2) @(posedge CLOCK);
    RST_N <= 1'b1;
    reg_scenario();
    pull_scenario();
    static_scenario();
    timer_scenario();
    restart_scenario();
    give_verdict();
  end
endmodule : wake_input_cyclic_sense_cfg_test
`default_nettype wire

// *** dv/wake_switch_model.sv ***
// Holds a model of the switches that sit on the three wake pins.
// Assumes a closed switch ties the pin high and an open pin follows the chosen pull.
`timescale 1ns/1ps
`default_nettype none
module wake_switch_model
(
  input wire logic clock,
  input wire logic [2:0] closed,
  input wire logic [2:0] pull_up_on,
  input wire logic [2:0] pull_down_on,
  output logic [2:0] wake_pin
);
  // Toggles every cycle, so a pin with no pull never looks settled.
  logic float_level = 1'b0;
  // A floating pin toggles, because the simulator would otherwise pick a level.
  always @(posedge clock)
  begin
    float_level <= ~float_level;
  end
  // A closed switch wins; an open pin follows its pull or floats.
  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      if (closed[i])
        wake_pin[i] = 1'b1;
      else if (pull_up_on[i])
        wake_pin[i] = 1'b1;
      else if (pull_down_on[i])
        wake_pin[i] = 1'b0;
      else
        wake_pin[i] = float_level;
    end
  end
endmodule : wake_switch_model
`default_nettype wire

// *** rtl/wake_cfg_consts.svh ***
// Holds the offsets, field positions, reset values and timing figures of the wake block.
// Assumes a 20 MHz core clock and an 8-bit register port with a 7-bit address.
`ifndef WAKE_CFG_CONSTS_SVH
`define WAKE_CFG_CONSTS_SVH
`define ADDR_WAKE_PULL 7'h08
`define ADDR_WAKE_FILTER 7'h09
`define ADDR_TIMER_ONE 7'h0C
`define CFG_FIELD_MASK 8'h3F
`define TIMER_CTRL_MASK 8'h77
`define REG_RESET 8'h00
`define ON_LSB 4
`define HS_CODE_TIMER_ONE 3'h2
`define HS_CODE_TIMER_TWO 3'h3
`define CLOCK_MHZ 20
`define FILTER_SHORT_US 16
`define FILTER_LONG_US 64
`define FILTER_SHORT_CYC (`FILTER_SHORT_US * `CLOCK_MHZ)
`define FILTER_LONG_CYC (`FILTER_LONG_US * `CLOCK_MHZ)
`define TENTHS_PER_MS 10
`endif

// *** rtl/wake_cfg_pkg.sv ***
// Holds the types shared by the wake input and cyclic timer block.
// Assumes the constants header supplies every number.
package wake_cfg_pkg;
  // Filter selections of one wake input.
  typedef enum logic [1:0]
  {
    FILT_STATIC_SHORT = 2'h0,
    FILT_STATIC_LONG = 2'h1,
    FILT_CYCLIC_ONE = 2'h2,
    FILT_CYCLIC_TWO = 2'h3
  } filter_mode_type;
  // Pull selections of one wake input.
  typedef enum logic [1:0]
  {
    PULL_NONE = 2'h0,
    PULL_DOWN = 2'h1,
    PULL_UP = 2'h2,
    PULL_AUTO = 2'h3
  } pull_mode_type;
  // Phases of the cyclic timer.
  typedef enum logic [1:0]
  {
    TMR_IDLE = 2'h0,
    TMR_ON = 2'h1,
    TMR_OFF = 2'h2
  } timer_state_type;
endpackage : wake_cfg_pkg

// *** rtl/wake_input_cyclic_sense_cfg.sv ***
// Holds the wake input pull and filter configuration and the cyclic timer one.
// Assumes a register port already framed from the serial port, pins on WAKE_PIN, timer two end pulse from outside.
`include "wake_cfg_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module wake_input_cyclic_sense_cfg #(
  parameter int NUM_WAKE = 3,
  parameter int CYC_PER_MS = 20000
)
(
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic [6:0] REG_ADDR,
  input wire logic REG_WRITE,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  input wire logic RESTART,
  input wire logic HS_CLEARED,
  input wire logic [2:0] HS_CONFIG,
  input wire logic TIMER_TWO_ON_END,
  input wire logic TIMER_A_WAKE_ENABLE,
  input wire logic [2:0] WAKE_PIN,
  output logic [2:0] PULL_UP_ON,
  output logic [2:0] PULL_DOWN_ON,
  output logic [2:0] WAKE_LEVEL,
  output logic [2:0] WAKE_EVENT,
  output logic HIGH_SIDE_OUTPUT,
  output logic TIMER_WAKE
);
  // Configuration registers as software sees them.
  logic [7:0] wake_pull_config;
  logic [7:0] wake_filter_config;
  logic [7:0] cyclic_timer_one_control;
  logic [7:0] next_pull;
  logic [7:0] next_filter;
  logic [7:0] next_timer_ctrl;
  // Read data register.
  logic [7:0] next_rdata;
  // Set while any input uses a cyclic filter mode; gates the switch-clear rule.
  logic cyclic_any;

  // Returns the register the address names, with reserved bits forced low.
  function automatic logic [7:0] read_mux(input logic [6:0] a, input logic [7:0] p, input logic [7:0] f,
                                          input logic [7:0] t);
    case (a)
      `ADDR_WAKE_PULL: read_mux = p & `CFG_FIELD_MASK;
      `ADDR_WAKE_FILTER: read_mux = f & `CFG_FIELD_MASK;
      `ADDR_TIMER_ONE: read_mux = t & `TIMER_CTRL_MASK;
      default: read_mux = `REG_RESET;
    endcase
  endfunction : read_mux

  // Cycles of one on-time code; zero for the codes that do not run.
  // Every code follows CYC_PER_MS, so a shortened millisecond keeps the on-time to period ratios.
  function automatic logic [31:0] on_cycles(input logic [2:0] c);
    case (c)
      3'h1: on_cycles = 32'(CYC_PER_MS / `TENTHS_PER_MS);
      3'h2: on_cycles = 32'(3 * CYC_PER_MS / `TENTHS_PER_MS);
      3'h3: on_cycles = 32'(CYC_PER_MS);
      3'h4: on_cycles = 32'(10 * CYC_PER_MS);
      3'h5: on_cycles = 32'(20 * CYC_PER_MS);
      default: on_cycles = 32'h0;
    endcase
  endfunction : on_cycles

  // Cycles of one period code; the reserved code is treated as the shortest period.
  function automatic logic [31:0] period_cycles(input logic [2:0] c);
    case (c)
      3'h1: period_cycles = 32'(20 * CYC_PER_MS);
      3'h2: period_cycles = 32'(50 * CYC_PER_MS);
      3'h3: period_cycles = 32'(100 * CYC_PER_MS);
      3'h4: period_cycles = 32'(200 * CYC_PER_MS);
      3'h5: period_cycles = 32'(1000 * CYC_PER_MS);
      3'h6: period_cycles = 32'(2000 * CYC_PER_MS);
      default: period_cycles = 32'(10 * CYC_PER_MS);
    endcase
  endfunction : period_cycles

  // Register writes, restart handling and reads.
  always_comb
  begin
    next_pull = wake_pull_config;
    next_filter = wake_filter_config;
    next_timer_ctrl = cyclic_timer_one_control;
    if (REG_WRITE && REG_ADDR == `ADDR_WAKE_PULL)
    begin
      next_pull = REG_WDATA & `CFG_FIELD_MASK;
    end
    if (REG_WRITE && REG_ADDR == `ADDR_WAKE_FILTER)
    begin
      next_filter = REG_WDATA & `CFG_FIELD_MASK;
    end
    if (REG_WRITE && REG_ADDR == `ADDR_TIMER_ONE)
    begin
      next_timer_ctrl = REG_WDATA & `TIMER_CTRL_MASK;
    end
    // Restart keeps the six pull and filter configuration bits and clears timer one; reserved ones stay clear.
    if (RESTART)
    begin
      next_pull = wake_pull_config & `CFG_FIELD_MASK;
      next_filter = wake_filter_config & `CFG_FIELD_MASK;
      next_timer_ctrl = `REG_RESET;
    end
    // Cleared switches under cyclic sense would give false detections, so the timer goes too.
    if (HS_CLEARED && cyclic_any)
    begin
      next_timer_ctrl = `REG_RESET;
    end
    next_rdata = read_mux(REG_ADDR, next_pull, next_filter, next_timer_ctrl);
  end

  // Registers the configuration; reset clears all three.
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      wake_pull_config <= `REG_RESET;
      wake_filter_config <= `REG_RESET;
      cyclic_timer_one_control <= `REG_RESET;
      REG_RDATA <= `REG_RESET;
    end
    else
    begin
      wake_pull_config <= next_pull;
      wake_filter_config <= next_filter;
      cyclic_timer_one_control <= next_timer_ctrl;
      REG_RDATA <= next_rdata;
    end
  end

  // Decoded timer fields.
  logic [2:0] on_code;
  logic [2:0] per_code;
  logic assigned;
  assign on_code = cyclic_timer_one_control[`ON_LSB +: 3];
  assign per_code = cyclic_timer_one_control[2:0];
  assign assigned = (HS_CONFIG == `HS_CODE_TIMER_ONE);
  always_comb
  begin
    cyclic_any = 1'b0;
    for (int i = 0; i < NUM_WAKE; i++)
    begin
      cyclic_any = cyclic_any | wake_filter_config[2*i+1];
    end
  end

  // Timer state.
  wake_cfg_pkg::timer_state_type tstate;
  wake_cfg_pkg::timer_state_type next_tstate;
  logic [31:0] tcount;
  logic [31:0] next_tcount;
  logic next_hs;
  logic on_end_one;
  logic next_on_end;
  logic next_timer_wake;

  // Timer phase sequencing: on-time at the start of each period, then off.
  always_comb
  begin
    next_tstate = tstate;
    next_tcount = tcount + 32'h1;
    next_on_end = 1'b0;
    next_hs = 1'b0;
    next_timer_wake = 1'b0;
    // A non-running code or a missing assignment parks the timer.
    if (!assigned || on_cycles(on_code) == 32'h0)
    begin
      next_tstate = wake_cfg_pkg::TMR_IDLE;
      next_tcount = 32'h0;
      next_hs = assigned && (on_code == 3'h6);
    end
    else
    begin
      case (tstate)
        wake_cfg_pkg::TMR_IDLE:
        begin
          next_tstate = wake_cfg_pkg::TMR_ON;
          next_tcount = 32'h1;
          next_hs = 1'b1;
        end
        wake_cfg_pkg::TMR_ON:
        begin
          next_hs = 1'b1;
          if (tcount >= on_cycles(on_code))
          begin
            next_tstate = wake_cfg_pkg::TMR_OFF;
            next_hs = 1'b0;
            next_on_end = 1'b1;
            next_timer_wake = TIMER_A_WAKE_ENABLE;
          end
        end
        wake_cfg_pkg::TMR_OFF:
        begin
          if (tcount >= period_cycles(per_code))
          begin
            next_tstate = wake_cfg_pkg::TMR_ON;
            next_tcount = 32'h1;
            next_hs = 1'b1;
          end
        end
        default:
        begin
          next_tstate = wake_cfg_pkg::TMR_IDLE;
          next_tcount = 32'h0;
        end
      endcase
    end
  end

  // Registers the timer; outputs come straight from these flops.
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      tstate <= wake_cfg_pkg::TMR_IDLE;
      tcount <= 32'h0;
      HIGH_SIDE_OUTPUT <= 1'b0;
      on_end_one <= 1'b0;
      TIMER_WAKE <= 1'b0;
    end
    else
    begin
      tstate <= next_tstate;
      tcount <= next_tcount;
      HIGH_SIDE_OUTPUT <= next_hs;
      on_end_one <= next_on_end;
      TIMER_WAKE <= next_timer_wake;
    end
  end

  // Per-input synchroniser, filter, and pull control.
  genvar g;
  generate
    for (g = 0; g < NUM_WAKE; g++)
    begin : gen_wake
      logic sync_a;
      logic sync_b;
      logic last;
      logic [11:0] stable;
      logic [11:0] next_stable;
      logic level;
      logic next_level;
      logic evt;
      logic next_evt;
      logic pu;
      logic pd;
      logic next_pu;
      logic next_pd;
      wake_cfg_pkg::filter_mode_type fmode;
      wake_cfg_pkg::pull_mode_type pmode;
      assign fmode = wake_cfg_pkg::filter_mode_type'(wake_filter_config[2*g +: 2]);
      assign pmode = wake_cfg_pkg::pull_mode_type'(wake_pull_config[2*g +: 2]);

      // Filter decision and pull selection for this input.
      always_comb
      begin
        next_stable = (sync_b == last) ? stable + 12'h1 : 12'h0;
        if (stable == 12'hFFF)
        begin
          next_stable = stable;
        end
        next_level = level;
        next_evt = 1'b0;
        case (fmode)
          wake_cfg_pkg::FILT_STATIC_SHORT:
            if (stable >= 12'(`FILTER_SHORT_CYC)) next_level = last;
          wake_cfg_pkg::FILT_STATIC_LONG:
            if (stable >= 12'(`FILTER_LONG_CYC)) next_level = last;
          wake_cfg_pkg::FILT_CYCLIC_ONE:
            if (on_end_one && stable >= 12'(`FILTER_SHORT_CYC)) next_level = last;
          default:
            if (TIMER_TWO_ON_END && stable >= 12'(`FILTER_SHORT_CYC)) next_level = last;
        endcase
        next_evt = (next_level != level);
        // Automatic pull follows the accepted level, so an open input is held where the filter last saw it.
        next_pu = 1'b0;
        next_pd = 1'b0;
        case (pmode)
          wake_cfg_pkg::PULL_DOWN: next_pd = 1'b1;
          wake_cfg_pkg::PULL_UP: next_pu = 1'b1;
          wake_cfg_pkg::PULL_AUTO:
          begin
            next_pu = level;
            next_pd = !level;
          end
          default: next_pu = 1'b0;
        endcase
      end

      // Registers synchroniser, filter and pull state.
      always_ff @(posedge CLOCK)
      begin
        if (!RST_N)
        begin
          sync_a <= 1'b0;
          sync_b <= 1'b0;
          last <= 1'b0;
          stable <= 12'h0;
          level <= 1'b0;
          evt <= 1'b0;
          pu <= 1'b0;
          pd <= 1'b0;
        end
        else
        begin
          sync_a <= WAKE_PIN[g];
          sync_b <= sync_a;
          last <= sync_b;
          stable <= next_stable;
          level <= next_level;
          evt <= next_evt;
          pu <= next_pu;
          pd <= next_pd;
        end
      end
      assign PULL_UP_ON[g] = pu;
      assign PULL_DOWN_ON[g] = pd;
      assign WAKE_LEVEL[g] = level;
      assign WAKE_EVENT[g] = evt;

      // An input on cyclic timer one may only change level right after a timer one on-end.
      a_cyclic_sample: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (fmode == wake_cfg_pkg::FILT_CYCLIC_ONE && $stable(fmode) && !$past(on_end_one)) |-> $stable(level))
        else $error("cyclic input changed outside on-end");
    end
  endgenerate

  // On-time 000 keeps the switch low.
  a_on_zero_low: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (on_code == 3'h0) ##1 (on_code == 3'h0) |-> !HIGH_SIDE_OUTPUT)
    else $error("switch high with on-time off");
  // On-time 110 with assignment keeps the switch high.
  a_on_six_high: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (on_code == 3'h6 && assigned) |=> HIGH_SIDE_OUTPUT)
    else $error("switch low with on-time high code");
  // Reserved bits 7 and 3 of the timer one register never read as one.
  a_reserved_zero: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (REG_ADDR == `ADDR_TIMER_ONE) |=> (REG_RDATA[7] == 1'b0 && REG_RDATA[3] == 1'b0))
    else $error("reserved bit read as one");
  // Restart clears the timer register next cycle.
  a_restart_clear: assert property (@(posedge CLOCK) disable iff (!RST_N)
    RESTART |=> (cyclic_timer_one_control == `REG_RESET))
    else $error("timer not cleared by restart");
  // Restart keeps the pull fields.
  a_restart_keep: assert property (@(posedge CLOCK) disable iff (!RST_N)
    RESTART |=> (wake_pull_config[5:0] == $past(wake_pull_config[5:0])))
    else $error("pull fields lost on restart");
  // Clearing switches under cyclic sense clears the timer.
  a_hs_clear: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (HS_CLEARED && cyclic_any) |=> (cyclic_timer_one_control == `REG_RESET))
    else $error("timer kept after switch clear");
  // Writing a running on-time to an assigned timer turns the switch on in two cycles.
  // A restart or a switch clear in the write cycle overrides the write, so it is excluded.
  sequence s_start;
    assigned && tstate == wake_cfg_pkg::TMR_IDLE && REG_WRITE && REG_ADDR == `ADDR_TIMER_ONE
      && !RESTART && !(HS_CLEARED && cyclic_any)
      && REG_WDATA[`ON_LSB +: 3] inside {3'h1, 3'h2, 3'h3, 3'h4, 3'h5};
  endsequence
  a_auto_start: assert property (@(posedge CLOCK) disable iff (!RST_N)
    s_start ##1 (assigned && !RESTART && !HS_CLEARED) |=> HIGH_SIDE_OUTPUT)
    else $error("timer did not start");
  // The switch drops exactly when an on-end pulse is produced.
  a_on_end_drop: assert property (@(posedge CLOCK) disable iff (!RST_N)
    $rose(on_end_one) |-> ($fell(HIGH_SIDE_OUTPUT) && TIMER_WAKE == $past(TIMER_A_WAKE_ENABLE)))
    else $error("on-end without switch drop");
endmodule : wake_input_cyclic_sense_cfg
`default_nettype wire
